// *** rtl/bacq_ctrl_status.v ***
// control and high status registers of the acquisition unit
// assumes a synchronous 16-bit processor bus; event strobes are from the clk domain
`default_nettype none
`include "bacq_regs.vh"
module bacq_ctrl_status (
  input wire clk,
  input wire rst,
  input wire [15:0] bus_addr,
  input wire bus_sel,
  input wire bus_wr,
  input wire [15:0] bus_wdata,
  output reg [15:0] bus_rdata,
  input wire v_meas_done_evt,
  input wire i_meas_done_evt,
  input wire ext_temp_done_evt,
  input wire int_temp_done_evt,
  input wire v_result_latch,
  input wire i_result_latch,
  input wire v_result_read,
  input wire i_result_read,
  input wire gain_change_evt,
  input wire analog_lv_reset_evt,
  input wire shunt_open_raw,
  output reg charge_counter_clear,
  output reg aux_sense_select,
  output reg shunt_detect_enable,
  output reg shunt_open_valid,
  output reg ext_temp_enable,
  output reg int_temp_enable,
  output reg v_channel_enable,
  output reg i_channel_enable,
  output reg meas_irq
);
  reg [6:0] ctl;
  reg [7:0] acquisition_status;
  reg [7:0] next_status;
  reg [6:0] next_ctl;
  reg [15:0] next_rdata;
  reg s1, s2;
  reg shunt_meta;
  reg shunt_sync;
  wire v_lost;
  wire i_lost;
  wire [7:0] set_evt;
  wire ctl_hit;
  wire sr_hit;
  wire ctl_wr;
  wire ctl_rd;
  wire sr_wr;
  wire sr_rd;
  wire [6:0] wmask;
  wire clear_req;
  wire irq_cause;
  wire [7:0] clr;
  integer k;

  // accept either the blocking or the non-blocking alias of the block
  function hit;
    input [15:0] a;
    input [15:0] ofs;
    begin
      hit = (a == (`BACQ_BASE_BLOCK + ofs)) || (a == (`BACQ_BASE_NONBLOCK + ofs));
    end
  endfunction

  assign ctl_hit = bus_sel & hit(bus_addr, `BACQ_CTL_OFS);
  assign sr_hit = bus_sel & hit(bus_addr, `BACQ_SR_OFS);
  // only full 16-bit writes exist on this port, so no byte lane logic

  bacq_lost_track u_vlost (
    .clk(clk),
    .rst(rst),
    .result_latch(v_result_latch),
    .result_read(v_result_read),
    .overwrite(v_lost)
  );
  bacq_lost_track u_ilost (
    .clk(clk),
    .rst(rst),
    .result_latch(i_result_latch),
    .result_read(i_result_read),
    .overwrite(i_lost)
  );

  // low-voltage reset strap is a pin level; synchronise before use
  always @(posedge clk) begin
    if (rst) begin
      s1 <= 1'h0;
      s2 <= 1'h0;
    end else begin
      s1 <= analog_lv_reset_evt;
      s2 <= s1;
    end
  end

  // shunt comparator runs off the analog side; only shunt_sync is read by logic
  always @(posedge clk) begin
    if (rst) begin
      shunt_meta <= 1'h0;
      shunt_sync <= 1'h0;
    end else begin
      shunt_meta <= shunt_open_raw;
      shunt_sync <= shunt_meta;
    end
  end

  assign ctl_wr = ctl_hit & bus_wr;
  assign ctl_rd = ctl_hit & ~bus_wr;
  assign sr_wr = sr_hit & bus_wr;
  assign sr_rd = sr_hit & ~bus_wr;
  // upper byte of the control word carries one write mask per stored bit
  assign wmask = bus_wdata[`BACQ_CTL_BITS + `BACQ_MASK_SHIFT - 1:`BACQ_MASK_SHIFT];
  // the clear bit is a command, not a stored field, so it gets its own mask test
  assign clear_req = ctl_wr & bus_wdata[`BACQ_BIT_CLR + `BACQ_MASK_SHIFT]
    & bus_wdata[`BACQ_BIT_CLR];

  assign set_evt = {s2, gain_change_evt, v_lost, i_lost,
    ext_temp_done_evt, int_temp_done_evt, v_meas_done_evt, i_meas_done_evt};
  // status sits in the high byte of the word at its offset
  assign clr = sr_wr ? bus_wdata[`BACQ_SR_HI:`BACQ_SR_LO] : 8'h00;

  always @* begin
    next_ctl = ctl;
    for (k = 0; k < `BACQ_CTL_BITS; k = k + 1) begin
      if (ctl_wr & wmask[k]) begin
        next_ctl[k] = bus_wdata[k];
      end
    end
  end

  always @* begin
    // set wins over clear so an event in the clearing cycle is kept
    next_status = (acquisition_status & ~clr) | set_evt;
  end

  // only voltage and current completion reach the request line
  assign irq_cause = next_status[`BACQ_SR_VDONE] | next_status[`BACQ_SR_IDONE];

  always @* begin
    if (ctl_rd) begin
      next_rdata = {9'h000, ctl};
    end else if (sr_rd) begin
      next_rdata = {acquisition_status, 8'h00};
    end else begin
      next_rdata = 16'h0000;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      ctl <= `BACQ_CTL_RESET;
    end else begin
      ctl <= next_ctl;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      acquisition_status <= `BACQ_SR_RESET;
    end else begin
      acquisition_status <= next_status;
    end
  end

  // write-only pulse, never stored, so a later write cannot replay it
  always @(posedge clk) begin
    if (rst) begin
      charge_counter_clear <= 1'h0;
    end else begin
      charge_counter_clear <= clear_req;
    end
  end

  // outputs copy next_ctl so they move on the same edge as the register itself
  always @(posedge clk) begin
    if (rst) begin
      aux_sense_select <= 1'h0;
    end else begin
      aux_sense_select <= next_ctl[`BACQ_BIT_AUX];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      shunt_detect_enable <= 1'h0;
    end else begin
      shunt_detect_enable <= next_ctl[`BACQ_BIT_SHUNT];
    end
  end

  // masked here so software never sees a stale open status while detection is off
  always @(posedge clk) begin
    if (rst) begin
      shunt_open_valid <= 1'h0;
    end else begin
      shunt_open_valid <= next_ctl[`BACQ_BIT_SHUNT] & shunt_sync;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      ext_temp_enable <= 1'h0;
    end else begin
      ext_temp_enable <= next_ctl[`BACQ_BIT_ETEMP];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      int_temp_enable <= 1'h0;
    end else begin
      int_temp_enable <= next_ctl[`BACQ_BIT_ITEMP];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      v_channel_enable <= 1'h0;
    end else begin
      v_channel_enable <= next_ctl[`BACQ_BIT_VCH];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      i_channel_enable <= 1'h0;
    end else begin
      i_channel_enable <= next_ctl[`BACQ_BIT_ICH];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      meas_irq <= 1'h0;
    end else begin
      meas_irq <= next_ctl[`BACQ_BIT_IRQEN] & irq_cause;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      bus_rdata <= 16'h0000;
    end else begin
      bus_rdata <= next_rdata;
    end
  end
endmodule // bacq_ctrl_status
`default_nettype wire

// *** include/bacq_regs.vh ***
// constants for the acquisition control and high status registers
// assumes a 16-bit processor bus with word-aligned offsets from the module base
// Functional notes
// - control bits 15..8 mask writes to the bit eight positions lower
// - block answers at its offset from base 0x0200 or 0x300; control at 0x58
// - unmasked write of 1 to clear bit zeroes the charge counter; 0 does nothing
// - sense select 0 routes battery input, 1 routes auxiliary input to converter
// - shunt open status is valid only while shunt detect enable is 1
// - measurement interrupt enable gates the current/voltage interrupt request
// - bits 3..0 enable ext temp, int temp, voltage and current channels
// - writing 1 to a status high bit clears it; writing 0 leaves it
// - status bit 7 set when last reset came from analog supply low voltage
// - status bit 6 set whenever amplifier gain changes, held until cleared
// - status bit 5 set when voltage result is overwritten since last clear
// - status bit 4 set when current result is overwritten since last clear
// - status bits 3 and 2 set on ext and int temperature completion
// - status bits 1 and 0 set on voltage and current completion
// - overwrite means new result latched before the previous one was read
// - gain change, overwrite and temperature flags raise no interrupt
`ifndef BACQ_REGS_VH
`define BACQ_REGS_VH
`define BACQ_BASE_BLOCK 16'h0200
`define BACQ_BASE_NONBLOCK 16'h0300
`define BACQ_CTL_OFS 16'h0058
`define BACQ_SR_OFS 16'h005A
`define BACQ_CTL_RESET 7'h00
`define BACQ_SR_RESET 8'h00
`define BACQ_BIT_CLR 7
`define BACQ_BIT_AUX 6
`define BACQ_BIT_SHUNT 5
`define BACQ_BIT_IRQEN 4
`define BACQ_BIT_ETEMP 3
`define BACQ_BIT_ITEMP 2
`define BACQ_BIT_VCH 1
`define BACQ_BIT_ICH 0
`define BACQ_MASK_SHIFT 8
`define BACQ_CTL_BITS 7
`define BACQ_SR_HI 15
`define BACQ_SR_LO 8
`define BACQ_SR_LVR 7
`define BACQ_SR_GAIN 6
`define BACQ_SR_VLOST 5
`define BACQ_SR_ILOST 4
`define BACQ_SR_ETDONE 3
`define BACQ_SR_ITDONE 2
`define BACQ_SR_VDONE 1
`define BACQ_SR_IDONE 0
`endif

// *** rtl/bacq_lost_track.v ***
// overwrite tracker for one result register
// assumes latch and read strobes are one-cycle pulses on clk
`default_nettype none
module bacq_lost_track (
  input wire clk,
  input wire rst,
  input wire result_latch,
  input wire result_read,
  output wire overwrite
);
  reg unread;
  // a read in the same cycle as a new latch leaves the new value unread
  assign overwrite = result_latch & unread & ~result_read;
  always @(posedge clk) begin
    if (rst) begin
      unread <= 1'h0;
    end else if (result_latch) begin
      unread <= 1'h1;
    end else if (result_read) begin
      unread <= 1'h0;
    end
  end
endmodule // bacq_lost_track
`default_nettype wire

// *** dv/bacq_sva.sv ***
// port assertions for the register block
// assumes a bind from the bench top
`default_nettype none
module bacq_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] bus_addr,
  input wire logic bus_sel,
  input wire logic bus_wr,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic v_meas_done_evt,
  input wire logic i_meas_done_evt,
  input wire logic shunt_detect_enable,
  input wire logic shunt_open_valid,
  input wire logic aux_sense_select,
  input wire logic v_channel_enable,
  input wire logic charge_counter_clear,
  input wire logic meas_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // both bases share one decode
  wire logic hit = bus_sel && bus_addr[15:9] == 7'h01;
  wire logic wc = hit && bus_wr && bus_addr[7:0] == 8'h58;
  wire logic ws = hit && bus_wr && bus_addr[7:0] == 8'h5A;
  wire logic rc = hit && !bus_wr && bus_addr[7:0] == 8'h58;
  wire logic ev = v_meas_done_evt || i_meas_done_evt;
  a_clr_pulse: assert property (wc && bus_wdata[15] && bus_wdata[7] |=> charge_counter_clear)
    else $error("clear pulse missing");
  a_clr_none: assert property (!(wc && bus_wdata[15] && bus_wdata[7]) |=> !charge_counter_clear)
    else $error("stray clear pulse");
  a_mask_hold: assert property (wc && !bus_wdata[9] |=> $stable(v_channel_enable))
    else $error("masked bit changed");
  a_vch_write: assert property (wc && bus_wdata[9] |=> v_channel_enable == $past(bus_wdata[1]))
    else $error("channel enable wrong");
  a_aux_write: assert property (wc && bus_wdata[14] |=> aux_sense_select == $past(bus_wdata[6]))
    else $error("sense select wrong");
  a_shunt_gate: assert property (!shunt_detect_enable |-> !shunt_open_valid)
    else $error("shunt status while off");
  a_irq_quiet: assert property (!meas_irq && !ev && !wc |=> !meas_irq)
    else $error("irq without cause");
  a_irq_clear: assert property (ws && bus_wdata[9:8] == 2'h3 && !ev |=> !meas_irq)
    else $error("irq after clear");
  a_ctl_zero: assert property (rc |=> bus_rdata[15:7] == 9'h000)
    else $error("mask bits read set");
  a_rd_idle: assert property (!(hit && !bus_wr) |=> bus_rdata == 16'h0000)
    else $error("read data not idle");
  c_clr: cover property (charge_counter_clear);
  c_irq: cover property (meas_irq);
  c_shunt: cover property (shunt_open_valid);
endmodule // bacq_sva
`default_nettype wire

// *** dv/bacq_cpu_model.sv ***
// processor model: one whole word per access
// assumes clk from the bench
`default_nettype none
module bacq_cpu_model (
  input wire logic clk,
  input wire logic [15:0] bus_rdata,
  output logic [15:0] bus_addr,
  output logic bus_sel,
  output logic bus_wr,
  output logic [15:0] bus_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {bus_sel, bus_wr, bus_addr, bus_wdata} = 34'h0;
  // no byte lanes: every access is 16 bits
  task automatic acc(input logic wr, input logic [15:0] a, d, output logic [15:0] q);
    @(posedge clk) #1;
    {bus_sel, bus_wr, bus_addr, bus_wdata} = {1'h1, wr, a, d};
    @(posedge clk) #1;
    q = bus_rdata;
    // released lines go inverse so stale values never pass
    {bus_sel, bus_addr, bus_wdata} = {1'h0, ~a, ~d};
  endtask
endmodule // bacq_cpu_model
`default_nettype wire

// *** dv/tb_battery_acq_ctrl_status_regs.sv ***
// bench top for the control and high status registers
// assumes the checker and processor model are compiled first
`default_nettype none
`define CHK(a, b) n_checks++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end
module tb_battery_acq_ctrl_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, lv = 1'h0, raw = 1'h0;
  logic [8:0] ev = 9'h000;
  logic [15:0] a, d, q;
  logic [6:0] e = 7'h00;
  logic [7:0] m;
  int fails = 0, n_checks = 0;
  wire [15:0] bus_addr, bus_wdata, bus_rdata;
  wire bus_sel, bus_wr, charge_counter_clear, aux_sense_select, shunt_detect_enable;
  wire shunt_open_valid, ext_temp_enable, int_temp_enable, v_channel_enable;
  wire i_channel_enable, meas_irq;
  always #2 clk = ~clk;
  bacq_cpu_model bacq_cpu_model_inst (
    .clk(clk),
    .bus_rdata(bus_rdata),
    .bus_addr(bus_addr),
    .bus_sel(bus_sel),
    .bus_wr(bus_wr),
    .bus_wdata(bus_wdata)
  );
  bacq_ctrl_status bacq_ctrl_status_inst (
    .clk(clk),
    .rst(rst),
    .bus_addr(bus_addr),
    .bus_sel(bus_sel),
    .bus_wr(bus_wr),
    .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata),
    .v_meas_done_evt(ev[1]),
    .i_meas_done_evt(ev[0]),
    .ext_temp_done_evt(ev[3]),
    .int_temp_done_evt(ev[2]),
    .v_result_latch(ev[6]),
    .i_result_latch(ev[5]),
    .v_result_read(ev[8]),
    .i_result_read(ev[7]),
    .gain_change_evt(ev[4]),
    .analog_lv_reset_evt(lv),
    .shunt_open_raw(raw),
    .charge_counter_clear(charge_counter_clear),
    .aux_sense_select(aux_sense_select),
    .shunt_detect_enable(shunt_detect_enable),
    .shunt_open_valid(shunt_open_valid),
    .ext_temp_enable(ext_temp_enable),
    .int_temp_enable(int_temp_enable),
    .v_channel_enable(v_channel_enable),
    .i_channel_enable(i_channel_enable),
    .meas_irq(meas_irq)
  );
  function automatic logic [6:0] f_ctl(input logic [6:0] o, input logic [15:0] x);
    return (o & ~x[14:8]) | (x[6:0] & x[14:8]);
  endfunction
  task automatic w(input logic [15:0] a, d);
    bacq_cpu_model_inst.acc(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, x);
    bacq_cpu_model_inst.acc(1'h0, a, 16'h0000, q);
    `CHK(q, x)
  endtask
  task automatic pl(input logic [8:0] b);
    @(posedge clk) #1 ev = b;
    @(posedge clk) #1 ev = 9'h000;
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(11505));
    repeat (20) @(posedge clk);
    #1 rst = 1'h0;
    rd(16'h0258, 16'h0000);
    for (int i = 0; i < 40; i++) begin
      d = $urandom;
      raw = d[2] ^ d[13];
      a = i[0] ? 16'h0358 : 16'h0258;
      w(a, d);
      e = f_ctl(e, d);
      rd(a ^ 16'h0100, {9'h000, e});
      `CHK({aux_sense_select, shunt_detect_enable}, e[6:5])
      `CHK({ext_temp_enable, int_temp_enable}, e[3:2])
      `CHK({v_channel_enable, i_channel_enable}, e[1:0])
      `CHK(shunt_open_valid, raw & e[5])
    end
    w(16'h025C, 16'hFFFF);
    w(16'h0258, 16'h007F);
    rd(16'h0258, {9'h000, e});
    rd(16'h025C, 16'h0000);
    $display("control test done");
    w(16'h035A, 16'hFF00);
    pl(9'h040); pl(9'h100); pl(9'h040);
    pl(9'h140);
    rd(16'h025A, 16'h0000);
    pl(9'h040); pl(9'h020); pl(9'h020); pl(9'h01F);
    lv = 1'h1;
    repeat (4) @(posedge clk);
    #1 lv = 1'h0;
    rd(16'h025A, 16'hFF00);
    m = $urandom;
    w(16'h025A, {m, 8'h00});
    rd(16'h035A, {~m, 8'h00});
    $display("status test done");
    w(16'h025A, 16'hFF00);
    w(16'h0258, 16'h1010); pl(9'h002);
    `CHK(meas_irq, 1'h1)
    w(16'h025A, 16'h0200);
    `CHK(meas_irq, 1'h0)
    pl(9'h05C);
    `CHK(meas_irq, 1'h0)
    w(16'h0258, 16'h1000); pl(9'h001);
    `CHK(meas_irq, 1'h0)
    w(16'h0258, 16'h1010);
    `CHK(meas_irq, 1'h1)
    w(16'h0258, 16'h8080);
    `CHK(charge_counter_clear, 1'h1)
    @(posedge clk) #1;
    `CHK(charge_counter_clear, 1'h0)
    $display("irq and clear test done");
    finish_test;
  end
endmodule // tb_battery_acq_ctrl_status_regs
bind bacq_ctrl_status bacq_sva bacq_sva_inst (
  .clk(clk),
  .rst(rst),
  .bus_addr(bus_addr),
  .bus_sel(bus_sel),
  .bus_wr(bus_wr),
  .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata),
  .v_meas_done_evt(v_meas_done_evt),
  .i_meas_done_evt(i_meas_done_evt),
  .shunt_detect_enable(shunt_detect_enable),
  .shunt_open_valid(shunt_open_valid),
  .aux_sense_select(aux_sense_select),
  .v_channel_enable(v_channel_enable),
  .charge_counter_clear(charge_counter_clear),
  .meas_irq(meas_irq)
);
`default_nettype wire
